// File: src/wcd_params.svh
// constants for the 64b/66b word codec
`ifndef WCD_PARAMS_SVH
`define WCD_PARAMS_SVH

`define WCD_WORD_W 66
`define WCD_BODY_W 64
`define WCD_SCR_LEN 58
`define WCD_SCR_TAP 39

`define WCD_SH_DATA 2'b10
`define WCD_SH_CTRL 2'b01

`define WCD_T_IDLE 8'h1E
`define WCD_T_I_SOF 8'h33
`define WCD_T_EOF_I 8'hB4
`define WCD_T_I_O 8'h2D
`define WCD_T_O_I 8'h4B
`define WCD_T_O_O 8'h55
`define WCD_T_O_SOF 8'h66
`define WCD_T_SOF_D 8'h78
`define WCD_T_D_EOF 8'hFF

`define WCD_CC_IDLE 7'h00
`define WCD_CC_LPI 7'h06
`define WCD_ORD_PSEQ 4'h0
`define WCD_ORD_PSIG 4'hF
`define WCD_EEE_EN 1'b1

`define WCD_RST_WORD 66'h0
`define WCD_RST_STATE 58'h0

`endif

// File: src/wcd_pkg.sv
// types shared by the word codec files
package wcd_pkg;
  typedef logic [7:0] wcd_type_t;
  typedef logic [6:0] wcd_code_t;
  typedef logic [63:0] wcd_body_t;
  typedef logic [65:0] wcd_word_t;

  // first byte on the line is bits 31:24 of a word
  function automatic logic [31:0] wcd_bswap(input logic [31:0] w);
    wcd_bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
endpackage

// File: src/wcd_scrambler.sv
// self-synchronizing x^58+x^39+1 scrambler / descrambler, 64 bits a word
`timescale 1ns/1ps
`include "wcd_params.svh"
module wcd_scrambler
  import wcd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic descramble_i,
  input wire logic [`WCD_BODY_W-1:0] din_i,
  output logic [`WCD_BODY_W-1:0] dout_o
);
  logic [`WCD_SCR_LEN-1:0] state_q;
  // ext[k] below the history length is the oldest line bit first
  logic [`WCD_SCR_LEN+`WCD_BODY_W-1:0] ext;

  assign ext[`WCD_SCR_LEN-1:0] = state_q;

  genvar i;
  generate
    for (i = 0; i < `WCD_BODY_W; i++) begin : g_bit
      assign dout_o[i] = din_i[i] ^ ext[i] ^ ext[i+`WCD_SCR_LEN-`WCD_SCR_TAP];
      // history holds line bits: sent ones or received ones
      assign ext[`WCD_SCR_LEN+i] = descramble_i ? din_i[i] : dout_o[i];
    end
  endgenerate

  // state moves only by the model
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= `WCD_RST_STATE;
    end else begin
      state_q <= ext[`WCD_SCR_LEN+`WCD_BODY_W-1:`WCD_BODY_W];
    end
  end
endmodule // wcd_scrambler

// File: src/wcd_codec.sv
// 64b/66b word encoder and decoder with scrambling
//
// What this block does
// - body serialized from bit 0 upward
// - scrambled bits fill word from bit 2
// - descrambler fed word bits 2..65 ascending
// - descrambled bits fill body from bit 0
// - scrambler state untouched except by model
// - equal header bits: violation, two idles
// - data header lsb 0, msb 1
// - data bytes big-endian per word, rising
// - control header lsb 1, msb 0
// - top body byte is word type
// - types 1E, 33, B4 for idle/delimiters
// - types 2D, 4B, 55 for other functions
// - types 66, 78, FF
// - undefined type never sent; received is violation
// - delimiters: type plus three modifier bytes
// - idles as four 7-bit control codes
// - encoder emits only idle or LPI codes
// - bad received code: violation, becomes idle
// - LPI code replaces idle code on request
// - error code 1E never sent by encoder
// - order code 0 or F plus modifiers
// - bad received order: violation, becomes idle
// - word leaves lsb first
`timescale 1ns/1ps
`include "wcd_params.svh"
module wcd_codec
  import wcd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic tx_ctrl_i,
  input wire logic [7:0] tx_type_i,
  input wire logic tx_lpi_i,
  input wire logic [31:0] tx_word_a_i,
  input wire logic [31:0] tx_word_b_i,
  output logic [`WCD_WORD_W-1:0] tx_word_o,
  output logic tx_reject_o,
  input wire logic [`WCD_WORD_W-1:0] rx_word_i,
  output logic rx_ctrl_o,
  output logic [7:0] rx_type_o,
  output logic [31:0] rx_word_a_o,
  output logic [31:0] rx_word_b_o,
  output logic rx_lpi_o,
  output logic rx_viol_o
);
  function automatic logic ord_ok(input logic [3:0] o);
    ord_ok = (o == `WCD_ORD_PSEQ) || (o == `WCD_ORD_PSIG);
  endfunction

  function automatic logic type_ok(input wcd_type_t t);
    case (t)
      `WCD_T_IDLE, `WCD_T_I_SOF, `WCD_T_EOF_I, `WCD_T_I_O, `WCD_T_O_I,
      `WCD_T_O_O, `WCD_T_O_SOF, `WCD_T_SOF_D, `WCD_T_D_EOF: type_ok = 1'b1;
      default: type_ok = 1'b0;
    endcase
  endfunction

  // other function slot: modifiers above a 4-bit order code
  function automatic logic [27:0] sf_slot(input logic [31:0] w);
    sf_slot = {w[23:0], ord_ok(w[27:24]) ? w[27:24] : `WCD_ORD_PSIG};
  endfunction

  // transmit side
  wcd_body_t tx_body_d;
  wcd_body_t tx_body_q;
  wcd_body_t tx_scr;
  logic [1:0] tx_sync_d;
  logic tx_rej_d;
  logic [`WCD_WORD_W-1:0] tx_word_q;
  logic tx_reject_q;
  wcd_code_t idle_c;
  logic [27:0] idle28;
  logic [27:0] sfa;
  logic [27:0] sfb;
  logic bad_a;
  logic bad_b;

  always_comb begin
    idle_c = tx_lpi_i ? `WCD_CC_LPI : `WCD_CC_IDLE;
    idle28 = {4{idle_c}};
    sfa = sf_slot(tx_word_a_i);
    sfb = sf_slot(tx_word_b_i);
    bad_a = !ord_ok(tx_word_a_i[27:24]);
    bad_b = !ord_ok(tx_word_b_i[27:24]);
    tx_body_d = {`WCD_T_IDLE, idle28, idle28};
    tx_sync_d = `WCD_SH_CTRL;
    tx_rej_d = 1'b0;
    if (!tx_ctrl_i) begin
      tx_body_d = {wcd_bswap(tx_word_b_i), wcd_bswap(tx_word_a_i)};
      tx_sync_d = `WCD_SH_DATA;
    end else begin
      case (tx_type_i)
        `WCD_T_IDLE: tx_body_d = {`WCD_T_IDLE, idle28, idle28};
        `WCD_T_I_SOF: tx_body_d = {`WCD_T_I_SOF, 4'h0, tx_word_b_i[23:0], idle28};
        `WCD_T_EOF_I: tx_body_d = {`WCD_T_EOF_I, idle28, 4'h0, tx_word_a_i[23:0]};
        `WCD_T_I_O: begin
          tx_body_d = {`WCD_T_I_O, sfb, idle28};
          tx_rej_d = bad_b;
        end
        `WCD_T_O_I: begin
          tx_body_d = {`WCD_T_O_I, idle28, sfa};
          tx_rej_d = bad_a;
        end
        `WCD_T_O_O: begin
          tx_body_d = {`WCD_T_O_O, sfb, sfa};
          tx_rej_d = bad_a | bad_b;
        end
        `WCD_T_O_SOF: begin
          tx_body_d = {`WCD_T_O_SOF, 4'h0, tx_word_b_i[23:0], sfa};
          tx_rej_d = bad_a;
        end
        `WCD_T_SOF_D: tx_body_d = {`WCD_T_SOF_D, wcd_bswap(tx_word_b_i), tx_word_a_i[23:0]};
        `WCD_T_D_EOF: tx_body_d = {`WCD_T_D_EOF, tx_word_b_i[23:0], wcd_bswap(tx_word_a_i)};
        default: tx_rej_d = 1'b1;
      endcase
    end
  end

  wcd_scrambler u_tx_scr (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .descramble_i(1'b0),
    .din_i(tx_body_d),
    .dout_o(tx_scr)
  );

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_word_q <= `WCD_RST_WORD;
      tx_body_q <= '0;
      tx_reject_q <= 1'b0;
    end else begin
      tx_word_q <= {tx_scr, tx_sync_d};
      tx_body_q <= tx_body_d;
      tx_reject_q <= tx_rej_d;
    end
  end

  // bit 0 is first on the line
  assign tx_word_o = tx_word_q;
  assign tx_reject_o = tx_reject_q;

  // receive side
  wcd_body_t rx_body_d;
  wcd_body_t rx_clean;
  logic [55:0] rx_codes;
  logic [7:0] code_bad;
  logic [7:0] code_lpi;
  logic rx_sync_ok;
  logic rx_is_ctrl;
  logic lo_idle;
  logic hi_idle;
  logic lo_sf;
  logic hi_sf;
  logic ord1_bad;
  logic ord2_bad;
  wcd_type_t rx_t;
  wcd_type_t rtype;
  logic rx_ctrl_d;
  logic [7:0] rx_type_d;
  logic [31:0] rx_a_d;
  logic [31:0] rx_b_d;
  logic rx_lpi_d;
  logic rx_viol_d;
  logic rx_ctrl_q;
  logic [7:0] rx_type_q;
  logic [31:0] rx_a_q;
  logic [31:0] rx_b_q;
  logic rx_lpi_q;
  logic rx_viol_q;

  wcd_scrambler u_rx_dscr (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .descramble_i(1'b1),
    .din_i(rx_word_i[`WCD_WORD_W-1:2]),
    .dout_o(rx_body_d)
  );

  assign rx_sync_ok = rx_word_i[0] ^ rx_word_i[1];
  assign rx_is_ctrl = (rx_word_i[1:0] == `WCD_SH_CTRL);
  assign rx_t = rx_body_d[63:56];

  always_comb begin
    lo_idle = 1'b0;
    hi_idle = 1'b0;
    lo_sf = 1'b0;
    hi_sf = 1'b0;
    case (rx_t)
      `WCD_T_IDLE: begin
        lo_idle = 1'b1;
        hi_idle = 1'b1;
      end
      `WCD_T_I_SOF: lo_idle = 1'b1;
      `WCD_T_EOF_I: hi_idle = 1'b1;
      `WCD_T_I_O: begin
        lo_idle = 1'b1;
        hi_sf = 1'b1;
      end
      `WCD_T_O_I: begin
        lo_sf = 1'b1;
        hi_idle = 1'b1;
      end
      `WCD_T_O_O: begin
        lo_sf = 1'b1;
        hi_sf = 1'b1;
      end
      `WCD_T_O_SOF: lo_sf = 1'b1;
      default: ;
    endcase
  end

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_code
      wcd_code_t c;
      logic in_idle;
      assign c = rx_body_d[7*k+6:7*k];
      assign in_idle = (k < 4) ? lo_idle : hi_idle;
      assign code_bad[k] = in_idle && !((c == `WCD_CC_IDLE) || (`WCD_EEE_EN && (c == `WCD_CC_LPI)));
      assign code_lpi[k] = in_idle && `WCD_EEE_EN && (c == `WCD_CC_LPI);
      assign rx_codes[7*k+6:7*k] = code_bad[k] ? `WCD_CC_IDLE : c;
    end
  endgenerate

  always_comb begin
    ord1_bad = lo_sf && !ord_ok(rx_body_d[3:0]);
    ord2_bad = hi_sf && !ord_ok(rx_body_d[31:28]);
    rx_clean = {rx_t, rx_codes};
    if (ord1_bad) begin
      rx_clean[27:0] = '0;
    end
    if (ord2_bad) begin
      rx_clean[55:28] = '0;
    end
    rtype = rx_t;
    case (rx_t)
      `WCD_T_O_O: begin
        if (ord1_bad && ord2_bad) begin
          rtype = `WCD_T_IDLE;
        end else if (ord1_bad) begin
          rtype = `WCD_T_I_O;
        end else if (ord2_bad) begin
          rtype = `WCD_T_O_I;
        end
      end
      `WCD_T_I_O: if (ord2_bad) rtype = `WCD_T_IDLE;
      `WCD_T_O_I: if (ord1_bad) rtype = `WCD_T_IDLE;
      `WCD_T_O_SOF: if (ord1_bad) rtype = `WCD_T_I_SOF;
      default: ;
    endcase
    rx_ctrl_d = rx_is_ctrl;
    rx_type_d = rtype;
    rx_lpi_d = rx_is_ctrl && type_ok(rx_t) && (|code_lpi);
    rx_viol_d = rx_is_ctrl && (ord1_bad || ord2_bad || (|code_bad));
    rx_a_d = '0;
    rx_b_d = '0;
    if (!rx_sync_ok || (rx_is_ctrl && !type_ok(rx_t))) begin
      rx_ctrl_d = 1'b1;
      rx_type_d = `WCD_T_IDLE;
      rx_viol_d = 1'b1;
      rx_lpi_d = 1'b0;
    end else if (!rx_is_ctrl) begin
      // body bit 0 from first descrambled bit
      rx_a_d = wcd_bswap(rx_body_d[31:0]);
      rx_b_d = wcd_bswap(rx_body_d[63:32]);
    end else begin
      case (rtype)
        `WCD_T_IDLE, `WCD_T_I_O, `WCD_T_O_I, `WCD_T_O_O: begin
          rx_a_d = {4'h0, rx_clean[3:0], rx_clean[27:4]};
          rx_b_d = {4'h0, rx_clean[31:28], rx_clean[55:32]};
          // idle slots hand over the cleaned four codes
          if (rtype == `WCD_T_IDLE || rtype == `WCD_T_I_O) begin
            rx_a_d = {4'h0, rx_clean[27:0]};
          end
          if (rtype == `WCD_T_IDLE || rtype == `WCD_T_O_I) begin
            rx_b_d = {4'h0, rx_clean[55:28]};
          end
        end
        `WCD_T_I_SOF: begin
          rx_a_d = {4'h0, rx_clean[27:0]};
          rx_b_d = {8'h00, rx_clean[51:28]};
        end
        `WCD_T_EOF_I: begin
          rx_a_d = {8'h00, rx_clean[23:0]};
          rx_b_d = {4'h0, rx_clean[55:28]};
        end
        `WCD_T_O_SOF: begin
          rx_a_d = {4'h0, rx_clean[3:0], rx_clean[27:4]};
          rx_b_d = {8'h00, rx_clean[51:28]};
        end
        `WCD_T_SOF_D: begin
          rx_a_d = {8'h00, rx_clean[23:0]};
          rx_b_d = wcd_bswap(rx_clean[55:24]);
        end
        `WCD_T_D_EOF: begin
          rx_a_d = wcd_bswap(rx_clean[31:0]);
          rx_b_d = {8'h00, rx_clean[55:32]};
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_ctrl_q <= 1'b1;
      rx_type_q <= `WCD_T_IDLE;
      rx_a_q <= '0;
      rx_b_q <= '0;
      rx_lpi_q <= 1'b0;
      rx_viol_q <= 1'b0;
    end else begin
      rx_ctrl_q <= rx_ctrl_d;
      rx_type_q <= rx_type_d;
      rx_a_q <= rx_a_d;
      rx_b_q <= rx_b_d;
      rx_lpi_q <= rx_lpi_d;
      rx_viol_q <= rx_viol_d;
    end
  end

  assign rx_ctrl_o = rx_ctrl_q;
  assign rx_type_o = rx_type_q;
  assign rx_word_a_o = rx_a_q;
  assign rx_word_b_o = rx_b_q;
  assign rx_lpi_o = rx_lpi_q;
  assign rx_viol_o = rx_viol_q;

  // checks
  logic chk_en_q;

  // release edge still sees reset in the flops, so checks start one edge later
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chk_en_q <= 1'b0;
    end else begin
      chk_en_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i || !chk_en_q);

  AST_TX_SYNC_DATA: assert property (!tx_ctrl_i |=> tx_word_o[1:0] == `WCD_SH_DATA)
    else $error("data word header wrong");
  AST_TX_SYNC_CTRL: assert property (tx_ctrl_i |=> tx_word_o[1:0] == `WCD_SH_CTRL)
    else $error("control word header wrong");
  AST_TX_DATA_BYTES: assert property (!tx_ctrl_i |=>
    tx_body_q[7:0] == $past(tx_word_a_i[31:24]) && tx_body_q[39:32] == $past(tx_word_b_i[31:24]))
    else $error("data byte order wrong");
  AST_TX_TYPE_LEGAL: assert property (tx_ctrl_i |=> type_ok(tx_body_q[63:56]))
    else $error("undefined word type sent");
  AST_TX_IDLE_CODE: assert property (tx_ctrl_i && tx_type_i == `WCD_T_IDLE |=>
    tx_body_q[6:0] == ($past(tx_lpi_i) ? `WCD_CC_LPI : `WCD_CC_IDLE) && tx_body_q[55:49] == tx_body_q[6:0])
    else $error("idle code wrong");
  AST_TX_SCR_TOP: assert property (tx_word_o[65] == (tx_body_q[63] ^ tx_word_o[26] ^ tx_word_o[7]))
    else $error("scrambler top bit wrong");
  AST_TX_SCR_CARRY: assert property (##1 tx_word_o[2] ==
    (tx_body_q[0] ^ $past(tx_word_o[27]) ^ $past(tx_word_o[8])))
    else $error("scrambler history not carried");
  AST_RX_DSCR_TOP: assert property (rx_body_d[63] == (rx_word_i[65] ^ rx_word_i[26] ^ rx_word_i[7]))
    else $error("descrambler top bit wrong");
  AST_RX_BAD_SYNC: assert property (rx_word_i[0] == rx_word_i[1] |=>
    rx_viol_o && rx_ctrl_o && rx_type_o == `WCD_T_IDLE && rx_word_a_o == '0 && rx_word_b_o == '0)
    else $error("bad header not turned into idles");
  AST_RX_BAD_TYPE: assert property (rx_is_ctrl && !type_ok(rx_t) |=>
    rx_viol_o && rx_type_o == `WCD_T_IDLE)
    else $error("undefined type not flagged");
  AST_RX_BAD_CODE: assert property (rx_is_ctrl && rx_t == `WCD_T_IDLE && rx_body_d[6:0] == 7'h1E |=>
    rx_viol_o && rx_word_a_o[6:0] == `WCD_CC_IDLE)
    else $error("bad control code not replaced");
  AST_RX_BAD_ORDER: assert property (rx_is_ctrl && rx_t == `WCD_T_I_O && !ord_ok(rx_body_d[31:28]) |=>
    rx_viol_o && rx_type_o == `WCD_T_IDLE && rx_word_b_o == '0)
    else $error("bad order code not replaced");

  COV_TX_DATA: cover property (!tx_ctrl_i ##1 tx_ctrl_i);
  COV_RX_VIOL: cover property (rx_viol_o);
  COV_RX_LPI: cover property (rx_lpi_o);
  COV_TX_REJECT: cover property (tx_reject_o);
endmodule // wcd_codec

// File: dv/wcd_line_model.sv
// line partner: descrambles the sent words and sends scrambled words back
`timescale 1ns/1ps
module wcd_line_model (
  input wire logic sys_clk_i,
  input wire logic [65:0] tx_word_i,
  input wire logic inj_i,
  input wire logic [65:0] inj_word_i,
  output logic [65:0] mon_word_o,
  output logic [65:0] rx_word_o
);
  // no particular start state needed, it syncs itself
  logic [57:0] dsc_q = '0;
  logic [57:0] scr_q = '0;
  logic [121:0] d;
  logic [121:0] s;

  function automatic logic [121:0] scr_f(input logic [63:0] b, input logic [57:0] st, input logic dsc);
    logic o;
    for (int i = 0; i < 64; i++) begin
      o = b[i] ^ st[38] ^ st[57];
      st = {st[56:0], dsc ? b[i] : o};
      b[i] = o;
    end
    return {st, b};
  endfunction

  always @(posedge sys_clk_i) begin
    d = scr_f(tx_word_i[65:2], dsc_q, 1'b1);
    dsc_q <= d[121:64];
    mon_word_o <= {d[63:0], tx_word_i[1:0]};
    // one scrambler for looped and injected words keeps the far end in sync
    s = scr_f(inj_i ? inj_word_i[65:2] : d[63:0], scr_q, 1'b0);
    scr_q <= s[121:64];
    rx_word_o <= {s[63:0], inj_i ? inj_word_i[1:0] : tx_word_i[1:0]};
  end
endmodule // wcd_line_model

// File: dv/word_codec_64b66b_tb.sv
// self-checking bench for the 64b/66b word codec
`timescale 1ns/1ps
module word_codec_64b66b_tb;
  logic sys_clk_i;
  logic rstn_i = 1'b0;
  logic tx_ctrl = 1'b0;
  logic [7:0] tx_type = 8'h1E;
  logic tx_lpi = 1'b0;
  logic [31:0] tx_a = '0;
  logic [31:0] tx_b = '0;
  logic inj = 1'b0;
  logic [65:0] inj_word = '0;
  logic [65:0] tx_word;
  logic [65:0] rx_word;
  logic [65:0] mon;
  logic tx_reject;
  logic rx_ctrl;
  logic rx_lpi;
  logic rx_viol;
  logic [7:0] rx_type;
  logic [31:0] rx_a;
  logic [31:0] rx_b;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] types [9] = '{8'h1E, 8'h33, 8'hB4, 8'h2D, 8'h4B, 8'h55, 8'h66, 8'h78, 8'hFF};

  wcd_codec dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .tx_ctrl_i(tx_ctrl), .tx_type_i(tx_type),
    .tx_lpi_i(tx_lpi), .tx_word_a_i(tx_a), .tx_word_b_i(tx_b), .tx_word_o(tx_word), .tx_reject_o(tx_reject),
    .rx_word_i(rx_word), .rx_ctrl_o(rx_ctrl), .rx_type_o(rx_type), .rx_word_a_o(rx_a), .rx_word_b_o(rx_b),
    .rx_lpi_o(rx_lpi), .rx_viol_o(rx_viol));
  wcd_line_model line (.sys_clk_i(sys_clk_i), .tx_word_i(tx_word), .inj_i(inj), .inj_word_i(inj_word),
    .mon_word_o(mon), .rx_word_o(rx_word));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] rev_bytes(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  task automatic chk_vec(input string name, input logic [65:0] exp, input logic [65:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_vec(name, {65'h0, exp}, {65'h0, got});
  endtask

  // three edges: design samples, partner samples, receiver answers
  task automatic send(input logic c, input logic [7:0] t, input logic l, input logic [31:0] a, input logic [31:0] b);
    @(posedge sys_clk_i);
    inj <= 1'b0;
    tx_ctrl <= c;
    tx_type <= t;
    tx_lpi <= l;
    tx_a <= a;
    tx_b <= b;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic inject_bad(input logic [1:0] sh, input logic [63:0] body, input logic [7:0] exp_type);
    @(posedge sys_clk_i);
    inj <= 1'b1;
    inj_word <= {body, sh};
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk_bit("rx_viol", 1'b1, rx_viol);
    chk_bit("rx_ctrl", 1'b1, rx_ctrl);
    chk_vec("rx_type", exp_type, rx_type);
    chk_vec("rx_a code", 7'h00, rx_a[6:0]);
  endtask

  task automatic test_data();
    send(1'b0, 8'h1E, 1'b0, 32'h0123_4567, 32'h89AB_CDEF);
    chk_vec("data header", 2'b10, mon[1:0]);
    chk_vec("data body", {rev_bytes(32'h89AB_CDEF), rev_bytes(32'h0123_4567)}, mon[65:2]);
    chk_vec("rx_a", 32'h0123_4567, rx_a);
    chk_vec("rx_b", 32'h89AB_CDEF, rx_b);
    chk_bit("rx_ctrl", 1'b0, rx_ctrl);
    chk_bit("rx_viol", 1'b0, rx_viol);
    $display("test_data done");
  endtask

  task automatic test_types();
    foreach (types[i]) begin
      send(1'b1, types[i], 1'b0, 32'h0F11_2233, 32'h0044_5566);
      chk_vec("ctrl header", 2'b01, mon[1:0]);
      chk_vec("tx type", types[i], mon[65:58]);
      chk_vec("rx_type", types[i], rx_type);
      chk_bit("tx_reject", 1'b0, tx_reject);
      chk_bit("rx_viol", 1'b0, rx_viol);
    end
    // start delimiter: three modifier bytes from word b, idle codes in the low slot
    send(1'b1, 8'h33, 1'b0, 32'h0, 32'h00A1_B2C3);
    chk_vec("sof mods", 24'hA1B2C3, mon[53:30]);
    chk_vec("rx sof mods", 24'hA1B2C3, rx_b[23:0]);
    chk_vec("idle slot", 28'h0, mon[29:2]);
    $display("test_types done");
  endtask

  task automatic test_lpi();
    send(1'b1, 8'h1E, 1'b1, 32'h0, 32'h0);
    chk_vec("lpi codes", {8{7'h06}}, mon[57:2]);
    chk_bit("rx_lpi", 1'b1, rx_lpi);
    chk_vec("rx lpi slot", {4{7'h06}}, rx_a[27:0]);
    send(1'b1, 8'h1E, 1'b0, 32'h0, 32'h0);
    chk_vec("idle codes", 56'h0, mon[57:2]);
    chk_bit("rx_lpi", 1'b0, rx_lpi);
    $display("test_lpi done");
  endtask

  task automatic test_tx_reject();
    send(1'b1, 8'h12, 1'b0, 32'h0, 32'h0);
    chk_bit("tx_reject", 1'b1, tx_reject);
    chk_vec("tx type", 8'h1E, mon[65:58]);
    send(1'b1, 8'h4B, 1'b0, 32'h0512_3456, 32'h0);
    chk_bit("tx_reject", 1'b1, tx_reject);
    chk_vec("order", 4'hF, mon[5:2]);
    $display("test_tx_reject done");
  endtask

  task automatic test_rx_faults();
    inject_bad(2'b11, 64'h0123_4567_89AB_CDEF, 8'h1E);
    chk_vec("rx_a", 32'h0, rx_a);
    inject_bad(2'b00, 64'h0123_4567_89AB_CDEF, 8'h1E);
    inject_bad(2'b01, 64'h1200_0000_0000_0000, 8'h1E);
    inject_bad(2'b01, 64'h1E00_0000_0000_001E, 8'h1E);
    inject_bad(2'b01, 64'h1E00_0000_0000_0011, 8'h1E);
    inject_bad(2'b01, 64'h2D00_0000_5000_0000, 8'h1E);
    inject_bad(2'b01, 64'h5500_0000_F000_0005, 8'h2D);
    $display("test_rx_faults done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the tests need about 104 cycles
  initial begin
    #(8 * 3000);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    test_data();
    test_types();
    test_lpi();
    test_tx_reject();
    test_rx_faults();
    test_data();
    final_report();
  end
endmodule // word_codec_64b66b_tb
